// ==== design/frame_builder_defines.vh ====
/*
 * Constants for the access error frame builder: register word offsets,
 * status word field positions, size and format codes, frame length.
 * Assumes it is included by bare name from the design file and the test bench.
 */
`ifndef FRAME_BUILDER_DEFINES_VH
`define FRAME_BUILDER_DEFINES_VH

`define OFF_STATUS_WORD  8'h00
`define OFF_ERR_LOC      8'h04
`define OFF_EFF_ADDR     8'h08
`define OFF_WB_STATUS    8'h0c
`define OFF_WB1_ADDR     8'h10
`define OFF_WB1_DATA     8'h14
`define OFF_WB2_ADDR     8'h18
`define OFF_WB2_DATA     8'h1c
`define OFF_WB3_ADDR     8'h20
`define OFF_WB3_DATA     8'h24
`define OFF_LINE0        8'h28
`define OFF_LINE1        8'h2c
`define OFF_LINE2        8'h30
`define OFF_LINE3        8'h34
`define OFF_FORMAT       8'h38
`define OFF_STATE        8'h3c

`define SW_POST          15
`define SW_UNIMPL        14
`define SW_TRACE         13
`define SW_MULTI         12
`define SW_MISALIGN      11
`define SW_XLATE         10
`define SW_LOCKED        9
`define SW_READ          8
`define SW_SIZE_LO       5
`define SW_TYPE_LO       3
`define WBS_VALID        7

`define SIZE_LONG        2'h0
`define SIZE_BYTE        2'h1
`define SIZE_WORD        2'h2
`define MOD_INSTR_USER   3'h2
`define MOD_INSTR_SUPER  3'h6
`define EA_MODE_PCREL    3'h7
`define EA_REG_PC_DISP   3'h2
`define EA_REG_PC_INDEX  3'h3
`define EA_MODE_INDEX    3'h6

`define FMT_ACCESS_ERR   4'h7
`define FMT_SIX_WORD     4'h2
`define FRAME_WORDS      6'h1e
`define TRACE_MOVE_BYTES 8'h30
`endif

// ==== design/access_error_frame_builder.v ====
/*
 * Access error frame builder: captures a faulted access into the frame
 * image, aligns write-back data, and runs the return-from-exception check.
 * Assumes fault, return and access inputs come from core logic on pclk,
 * and that software reaches the frame image over APB.
 */
`include "frame_builder_defines.vh"
module access_error_frame_builder (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         psel,
	input  wire         penable,
	input  wire         pwrite,
	input  wire [7:0]   paddr,
	input  wire [31:0]  pwdata,
	output reg  [31:0]  prdata,
	output reg          pready,
	output reg          pslverr,
	input  wire         fault_valid,
	input  wire         fault_is_instr,
	input  wire         fault_supervisor,
	input  wire         fault_nonresident,
	input  wire         fault_privilege,
	input  wire         fault_second_page,
	input  wire         fault_locked,
	input  wire         fault_read,
	input  wire [1:0]   fault_exec_size,
	input  wire [1:0]   fault_transfer_type,
	input  wire [2:0]   fault_transfer_mod,
	input  wire         fault_is_push,
	input  wire         fault_line_move_write,
	input  wire [31:0]  fault_logical_addr,
	input  wire [31:0]  fault_physical_addr,
	input  wire         fault_multi_move,
	input  wire         fault_pend_trace,
	input  wire         fault_pend_unimpl,
	input  wire         fault_pend_post,
	input  wire [31:0]  fault_eff_addr,
	input  wire [2:0]   fault_ea_mode,
	input  wire [2:0]   fault_ea_reg,
	input  wire [7:0]   hold1_status,
	input  wire [31:0]  hold1_addr,
	input  wire [31:0]  hold1_data,
	input  wire [7:0]   hold2_status,
	input  wire [31:0]  hold2_addr,
	input  wire [31:0]  hold2_data,
	input  wire [7:0]   hold3_status,
	input  wire [31:0]  hold3_addr,
	input  wire [31:0]  hold3_data,
	input  wire [127:0] line_image_in,
	input  wire         return_start,
	input  wire         validation_fault,
	input  wire         addr_err_valid,
	input  wire [31:0]  addr_err_pc,
	input  wire [31:0]  addr_err_addr,
	input  wire         acc_valid,
	input  wire         acc_read,
	input  wire         acc_rmw,
	input  wire         acc_pages_write_ok,
	output reg          return_done,
	output reg          return_format_exc,
	output reg          return_nested_push,
	output reg  [5:0]   return_sp_words,
	output reg          return_resume,
	output reg          return_restart_multi,
	output reg          return_reuse_ea,
	output reg  [2:0]   return_pending_exc,
	output reg  [31:0]  return_eff_addr,
	output reg          return_trace_move,
	output reg  [7:0]   return_trace_sp_bytes,
	output reg  [3:0]   return_new_format,
	output reg          short_frame_valid,
	output reg  [3:0]   short_frame_format,
	output reg  [31:0]  short_frame_pc,
	output reg  [31:0]  short_frame_addr,
	output reg          acc_write_check,
	output reg          acc_allowed
);
	localparam ST_IDLE  = 2'b01;
	localparam ST_CHECK = 2'b10;
	reg [15:0]  special_status_word_reg;
	reg [31:0]  errored_access_location_reg;
	reg [31:0]  eff_addr_reg;
	reg [7:0]   first_writeback_status_reg;
	reg [7:0]   second_writeback_status_reg;
	reg [7:0]   third_writeback_status_reg;
	reg [31:0]  first_writeback_address_reg;
	reg [31:0]  first_writeback_data_reg;
	reg [31:0]  second_writeback_address_reg;
	reg [31:0]  second_writeback_data_reg;
	reg [31:0]  third_writeback_address_reg;
	reg [31:0]  third_writeback_data_reg;
	reg [31:0]  line_image_words_reg [0:3];
	reg [3:0]   format_reg;
	reg [5:0]   ea_mode_reg;
	reg [1:0]   state_reg;
	reg [1:0]   state_next;
	wire        wr_access = psel & penable & pready & pwrite;
	wire [15:0] sw_now = special_status_word_reg;
	integer     i;
	// Register alignment keeps only the bytes the size covers.
	function [31:0] reg_align;
		input [1:0]  size;
		input [31:0] data;
		begin
			case (size)
				`SIZE_BYTE: reg_align = {24'h000000, data[7:0]};
				`SIZE_WORD: reg_align = {16'h0000, data[15:0]};
				default:    reg_align = data;
			endcase
		end
	endfunction
	// Data is first placed as if at lane 0, then rotated right one lane
	// per low address step, which gives the wrap-around of misaligned data.
	function [31:0] lane_align;
		input [1:0]  size;
		input [1:0]  a;
		input [31:0] data;
		reg   [31:0] base;
		reg   [63:0] both;
		begin
			case (size)
				`SIZE_BYTE: base = {data[7:0], 24'h000000};
				`SIZE_WORD: base = {data[15:0], 16'h0000};
				default:    base = data;
			endcase
			both = {base, base} >> {a, 3'h0};
			lane_align = both[31:0];
		end
	endfunction
	// Priority keeps the built word at a single resume bit.
	wire cont_multi  = fault_multi_move & ~fault_is_instr;
	wire cont_post   = ~cont_multi & fault_pend_post;
	wire cont_unimpl = ~cont_multi & ~fault_pend_post & fault_pend_unimpl;
	wire cont_trace  = ~cont_multi & ~fault_pend_post & ~fault_pend_unimpl &
		fault_pend_trace;
	wire [15:0] built_status = {cont_post, cont_unimpl, cont_trace,
		cont_multi,
		fault_second_page & (fault_nonresident | fault_privilege),
		fault_nonresident | fault_privilege,
		fault_locked,
		fault_read,
		1'b0,
		fault_exec_size,
		fault_transfer_type,
		fault_is_instr ? (fault_supervisor ? `MOD_INSTR_SUPER :
			`MOD_INSTR_USER) : fault_transfer_mod};
	wire [31:0] built_location = fault_is_push ? fault_physical_addr :
		fault_logical_addr;
	wire        no_writebacks = fault_is_instr;
	wire        first_invalid = no_writebacks | fault_is_push |
		fault_line_move_write;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			special_status_word_reg      <= 16'h0000;
			errored_access_location_reg  <= 32'h00000000;
			eff_addr_reg                 <= 32'h00000000;
			first_writeback_status_reg   <= 8'h00;
			second_writeback_status_reg  <= 8'h00;
			third_writeback_status_reg   <= 8'h00;
			first_writeback_address_reg  <= 32'h00000000;
			first_writeback_data_reg     <= 32'h00000000;
			second_writeback_address_reg <= 32'h00000000;
			second_writeback_data_reg    <= 32'h00000000;
			third_writeback_address_reg  <= 32'h00000000;
			third_writeback_data_reg     <= 32'h00000000;
			for (i = 0; i < 4; i = i + 1)
				line_image_words_reg[i] <= 32'h00000000;
			format_reg                   <= `FMT_ACCESS_ERR;
			ea_mode_reg                  <= 6'h00;
		end else if (fault_valid) begin
			// A new fault wins over a software write in the same cycle.
			special_status_word_reg     <= built_status;
			errored_access_location_reg <= built_location;
			eff_addr_reg                <= fault_eff_addr;
			ea_mode_reg                 <= {fault_ea_mode, fault_ea_reg};
			format_reg                  <= `FMT_ACCESS_ERR;
			first_writeback_status_reg  <= first_invalid ? 8'h00 :
				hold1_status;
			second_writeback_status_reg <= no_writebacks ? 8'h00 :
				hold2_status;
			third_writeback_status_reg  <= no_writebacks ? 8'h00 :
				hold3_status;
			first_writeback_address_reg <= fault_is_push ? built_location :
				hold1_addr;
			first_writeback_data_reg    <= lane_align(
				hold1_status[`SW_SIZE_LO+1:`SW_SIZE_LO], hold1_addr[1:0],
				hold1_data);
			second_writeback_address_reg <= hold2_addr;
			second_writeback_data_reg   <= reg_align(
				hold2_status[`SW_SIZE_LO+1:`SW_SIZE_LO], hold2_data);
			third_writeback_address_reg <= hold3_addr;
			third_writeback_data_reg    <= reg_align(
				hold3_status[`SW_SIZE_LO+1:`SW_SIZE_LO], hold3_data);
			for (i = 0; i < 4; i = i + 1)
				line_image_words_reg[i] <= line_image_in[i*32 +: 32];
		end else if (wr_access) begin
			case (paddr)
				`OFF_STATUS_WORD: special_status_word_reg <= pwdata[15:0];
				`OFF_ERR_LOC:     errored_access_location_reg <= pwdata;
				`OFF_EFF_ADDR:    eff_addr_reg <= pwdata;
				`OFF_WB_STATUS: begin
					first_writeback_status_reg  <= pwdata[7:0];
					second_writeback_status_reg <= pwdata[15:8];
					third_writeback_status_reg  <= pwdata[23:16];
				end
				`OFF_WB1_ADDR:    first_writeback_address_reg <= pwdata;
				`OFF_WB1_DATA:    first_writeback_data_reg <= pwdata;
				`OFF_WB2_ADDR:    second_writeback_address_reg <= pwdata;
				`OFF_WB2_DATA:    second_writeback_data_reg <= pwdata;
				`OFF_WB3_ADDR:    third_writeback_address_reg <= pwdata;
				`OFF_WB3_DATA:    third_writeback_data_reg <= pwdata;
				`OFF_LINE0:       line_image_words_reg[0] <= pwdata;
				`OFF_LINE1:       line_image_words_reg[1] <= pwdata;
				`OFF_LINE2:       line_image_words_reg[2] <= pwdata;
				`OFF_LINE3:       line_image_words_reg[3] <= pwdata;
				`OFF_FORMAT:      format_reg <= pwdata[3:0];
				default: ;
			endcase
		end
	end
	// One wait state: the slave answers in the second access cycle.
	reg [31:0] rd_next;
	reg        err_next;
	always @* begin
		rd_next  = 32'h00000000;
		err_next = 1'b0;
		case (paddr)
			`OFF_STATUS_WORD: rd_next = {16'h0000, sw_now};
			`OFF_ERR_LOC:     rd_next = errored_access_location_reg;
			`OFF_EFF_ADDR:    rd_next = eff_addr_reg;
			`OFF_WB_STATUS:   rd_next = {8'h00, third_writeback_status_reg,
				second_writeback_status_reg, first_writeback_status_reg};
			`OFF_WB1_ADDR:    rd_next = first_writeback_address_reg;
			`OFF_WB1_DATA:    rd_next = first_writeback_data_reg;
			`OFF_WB2_ADDR:    rd_next = second_writeback_address_reg;
			`OFF_WB2_DATA:    rd_next = second_writeback_data_reg;
			`OFF_WB3_ADDR:    rd_next = third_writeback_address_reg;
			`OFF_WB3_DATA:    rd_next = third_writeback_data_reg;
			`OFF_LINE0:       rd_next = line_image_words_reg[0];
			`OFF_LINE1:       rd_next = line_image_words_reg[1];
			`OFF_LINE2:       rd_next = line_image_words_reg[2];
			`OFF_LINE3:       rd_next = line_image_words_reg[3];
			`OFF_FORMAT:      rd_next = {28'h0000000, format_reg};
			`OFF_STATE:       rd_next = {24'h000000, ea_mode_reg, state_reg};
			default:          err_next = 1'b1;
		endcase
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & err_next;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_next :
				32'h00000000;
		end
	end
	always @* begin
		case (state_reg)
			ST_IDLE:  state_next = return_start ? ST_CHECK : ST_IDLE;
			ST_CHECK: state_next = ST_IDLE;
			default:  state_next = ST_IDLE;
		endcase
	end
	wire ea_reusable = (ea_mode_reg[5:3] == `EA_MODE_PCREL &&
		(ea_mode_reg[2:0] == `EA_REG_PC_DISP ||
		 ea_mode_reg[2:0] == `EA_REG_PC_INDEX)) ||
		ea_mode_reg[5:3] == `EA_MODE_INDEX;
	wire fmt_ok   = format_reg == `FMT_ACCESS_ERR;
	wire check_ok = (state_reg == ST_CHECK) & ~validation_fault & fmt_ok;
	wire any_cont = |sw_now[`SW_POST:`SW_MULTI];
	// Several resume bits set by software is undefined; the same priority
	// as the build is applied so the outcome at least stays repeatable.
	wire act_multi  = sw_now[`SW_MULTI];
	wire act_post   = ~act_multi & sw_now[`SW_POST];
	wire act_unimpl = ~act_multi & ~sw_now[`SW_POST] & sw_now[`SW_UNIMPL];
	wire act_trace  = ~act_multi & ~sw_now[`SW_POST] & ~sw_now[`SW_UNIMPL] &
		sw_now[`SW_TRACE];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg             <= ST_IDLE;
			return_done           <= 1'b0;
			return_format_exc     <= 1'b0;
			return_nested_push    <= 1'b0;
			return_sp_words       <= 6'h00;
			return_resume         <= 1'b0;
			return_restart_multi  <= 1'b0;
			return_reuse_ea       <= 1'b0;
			return_pending_exc    <= 3'h0;
			return_eff_addr       <= 32'h00000000;
			return_trace_move     <= 1'b0;
			return_trace_sp_bytes <= 8'h00;
			return_new_format     <= 4'h0;
		end else begin
			state_reg          <= state_next;
			return_done        <= check_ok;
			// The frame image is left untouched on either failure.
			return_format_exc  <= (state_reg == ST_CHECK) & ~fmt_ok;
			return_nested_push <= (state_reg == ST_CHECK) &
				validation_fault;
			return_sp_words    <= check_ok ? `FRAME_WORDS : 6'h00;
			return_resume      <= check_ok & ~any_cont;
			return_restart_multi <= check_ok & act_multi;
			return_reuse_ea    <= check_ok & act_multi & ea_reusable;
			return_pending_exc <= check_ok ?
				{act_post, act_unimpl, act_trace} : 3'h0;
			return_eff_addr    <= (check_ok & any_cont) ? eff_addr_reg :
				32'h00000000;
			return_trace_move  <= check_ok & act_trace;
			return_trace_sp_bytes <= (check_ok & act_trace) ?
				`TRACE_MOVE_BYTES : 8'h00;
			return_new_format  <= (check_ok & act_trace) ? `FMT_SIX_WORD :
				4'h0;
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			short_frame_valid  <= 1'b0;
			short_frame_format <= 4'h0;
			short_frame_pc     <= 32'h00000000;
			short_frame_addr   <= 32'h00000000;
			acc_write_check    <= 1'b0;
			acc_allowed        <= 1'b0;
		end else begin
			short_frame_valid  <= addr_err_valid;
			if (addr_err_valid) begin
				short_frame_format <= `FMT_SIX_WORD;
				short_frame_pc     <= addr_err_pc;
				short_frame_addr   <= {addr_err_addr[31:1], 1'b0};
			end
			// A locked read counts as a write so both halves see protection.
			acc_write_check <= acc_valid & (~acc_read | acc_rmw);
			acc_allowed     <= acc_valid &
				(acc_read & ~acc_rmw | acc_pages_write_ok);
		end
	end
endmodule

// ==== dv/access_error_frame_builder_chk.sv ====
/* Concurrent checks on the access error frame builder ports.
   Assumes it is bound to the builder and sees its ports by name. */
module access_error_frame_builder_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        addr_err_valid,
	input wire logic [31:0] addr_err_addr,
	input wire logic        short_frame_valid,
	input wire logic [3:0]  short_frame_format,
	input wire logic [31:0] short_frame_addr,
	input wire logic        acc_valid,
	input wire logic        acc_read,
	input wire logic        acc_rmw,
	input wire logic        acc_pages_write_ok,
	input wire logic        acc_write_check,
	input wire logic        acc_allowed,
	input wire logic        return_start,
	input wire logic        return_done,
	input wire logic        return_format_exc,
	input wire logic        return_nested_push,
	input wire logic [5:0]  return_sp_words,
	input wire logic        return_restart_multi,
	input wire logic [2:0]  return_pending_exc,
	input wire logic        return_trace_move,
	input wire logic [7:0]  return_trace_sp_bytes,
	input wire logic [3:0]  return_new_format
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	apb_wait_a: assert property (psel && !penable |-> ##2 pready)
		else $error("pready late after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	short_frame_a: assert property (addr_err_valid |=> short_frame_valid &&
		short_frame_format == 4'h2 &&
		short_frame_addr == ($past(addr_err_addr) & 32'hffff_fffe))
		else $error("address error frame wrong");
	write_check_a: assert property (
		acc_valid && (acc_rmw || !acc_read) |=> acc_write_check)
		else $error("write check missing");
	page_block_a: assert property (acc_rmw && !acc_pages_write_ok |=> !acc_allowed)
		else $error("locked access allowed on protected page");
	return_time_a: assert property (return_start |-> ##2
		(return_done || return_format_exc || return_nested_push))
		else $error("return gave no outcome");
	stack_pop_a: assert property (return_done |-> return_sp_words == 6'h1e)
		else $error("stack not popped by thirty words");
	frame_kept_a: assert property (return_format_exc || return_nested_push |->
		!return_done && return_sp_words == 6'h00)
		else $error("illegal frame was consumed");
	one_resume_a: assert property (return_done |->
		$onehot0({return_restart_multi, return_pending_exc}))
		else $error("several resume actions");
	trace_fix_a: assert property (return_trace_move |->
		return_trace_sp_bytes == 8'h30 && return_new_format == 4'h2 &&
		return_pending_exc == 3'h1)
		else $error("trace stack fix wrong");

	cover property (return_done && return_restart_multi);
	cover property (return_format_exc);
	cover property (return_nested_push);
	cover property (short_frame_valid);
endmodule

bind access_error_frame_builder access_error_frame_builder_chk chk_u (.*);

// ==== dv/access_error_frame_builder_test.sv ====
/* Self-checking bench for the access error frame builder.
   Assumes the builder's defines header is on the include path. */
`include "frame_builder_defines.vh"

module access_error_frame_builder_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, hold1_status, hold2_status, hold3_status;
	logic [7:0] return_trace_sp_bytes;
	logic [31:0] pwdata, prdata, fault_logical_addr, fault_physical_addr;
	logic [31:0] fault_eff_addr, hold1_addr, hold1_data, hold2_addr;
	logic [31:0] hold2_data, hold3_addr, hold3_data, addr_err_pc;
	logic [31:0] addr_err_addr, return_eff_addr, short_frame_pc;
	logic [31:0] short_frame_addr, q, lj, mk;
	logic fault_valid, fault_is_instr, fault_supervisor, fault_nonresident;
	logic fault_privilege, fault_second_page, fault_locked, fault_read;
	logic fault_is_push, fault_line_move_write, fault_multi_move;
	logic fault_pend_trace, fault_pend_unimpl, fault_pend_post, e;
	logic [1:0] fault_exec_size, fault_transfer_type, sz;
	logic [2:0] fault_transfer_mod, fault_ea_mode, fault_ea_reg;
	logic [2:0] return_pending_exc;
	logic [127:0] line_image_in;
	logic return_start, validation_fault, addr_err_valid, acc_valid;
	logic acc_read, acc_rmw, acc_pages_write_ok, return_done;
	logic return_format_exc, return_nested_push, return_resume;
	logic return_restart_multi, return_reuse_ea, return_trace_move;
	logic short_frame_valid, acc_write_check, acc_allowed;
	logic [5:0] return_sp_words;
	logic [3:0] return_new_format, short_frame_format;
	int fail_count, cmp_count;

	access_error_frame_builder dut_u (.*);

	always #12.5 pclk = ~pclk;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// The request stands until pready is sampled high at a rising edge;
	// data and error are taken at that edge, so a hang ends at the watchdog.
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk(32'(n), 32'h2);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk({31'h0, e}, 32'h0);
		chk(q, exp);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		chk({31'h0, e}, 32'h0);
	endtask

	// Flag order: instr, sup, nonres, priv, second page, locked, read,
	// push, line move write, multi move, trace, unimpl, post.
	task fset(input logic [12:0] f, input logic [1:0] s,
		input logic [1:0] t, input logic [2:0] m);
		{fault_is_instr, fault_supervisor, fault_nonresident,
		 fault_privilege, fault_second_page, fault_locked, fault_read,
		 fault_is_push, fault_line_move_write, fault_multi_move,
		 fault_pend_trace, fault_pend_unimpl, fault_pend_post} <= f;
		fault_exec_size <= s;
		fault_transfer_type <= t;
		fault_transfer_mod <= m;
	endtask

	task cap(input logic [12:0] f, input logic [1:0] s,
		input logic [1:0] t, input logic [2:0] m);
		fset(f, s, t, m);
		fault_valid <= 1'b1;
		@(posedge pclk);
		fault_valid <= 1'b0;
		@(posedge pclk);
	endtask

	// Expected vector: sp words, done, format, nested, resume, restart,
	// reuse, pending {post,unimpl,trace}, trace move.
	task ret(input logic vf, input logic [15:0] ev, input logic [31:0] ea);
		return_start <= 1'b1;
		validation_fault <= vf;
		@(posedge pclk);
		return_start <= 1'b0;
		@(posedge pclk);
		validation_fault <= 1'b0;
		@(negedge pclk);
		chk({16'h0, return_sp_words, return_done, return_format_exc,
			return_nested_push, return_resume, return_restart_multi,
			return_reuse_ea, return_pending_exc, return_trace_move}, {16'h0, ev});
		if (ev[9])
			chk(return_eff_addr, ea);
		chk({20'h0, return_new_format, return_trace_sp_bytes},
			ev[0] ? 32'h230 : 32'h0);
		@(posedge pclk);
	endtask

	task conclude();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		presetn <= 1'b0;
		{psel, penable, pwrite, paddr, pwdata} <= '0;
		{fault_valid, return_start, validation_fault, addr_err_valid} <= '0;
		{acc_valid, acc_read, acc_rmw, acc_pages_write_ok} <= '0;
		{addr_err_pc, addr_err_addr} <= '0;
		fault_logical_addr <= 32'h0001_0003;
		fault_physical_addr <= 32'h8000_0040;
		fault_eff_addr <= 32'h0000_3000;
		fault_ea_mode <= `EA_MODE_PCREL;
		fault_ea_reg <= `EA_REG_PC_DISP;
		{hold3_status, hold2_status, hold1_status} <= 24'ha9_c2_81;
		{hold1_addr, hold2_addr} <= {32'h0000_1001, 32'h0000_2000};
		hold3_addr <= 32'h0000_3004;
		{hold1_data, hold2_data, hold3_data} <= {3{32'ha1b2_c3d4}};
		line_image_in <= 128'h0f0e0d0c_0b0a0908_07060504_03020100;
		fset(13'h0, 2'h0, 2'h0, 3'h0);
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(`OFF_STATUS_WORD, 32'h0);
		rd(`OFF_FORMAT, 32'h7);
		rd(`OFF_STATE, 32'h1);
		xfer(1'b0, 8'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test reset done");
		cap(13'h05cf, `SIZE_WORD, 2'h1, 3'h5);
		rd(`OFF_STATUS_WORD, 32'h0000_1f4d);
		rd(`OFF_ERR_LOC, 32'h0001_0003);
		rd(`OFF_EFF_ADDR, 32'h0000_3000);
		rd(`OFF_WB_STATUS, 32'h00a9_c281);
		rd(`OFF_WB1_ADDR, 32'h0000_1001);
		rd(`OFF_WB2_ADDR, 32'h0000_2000);
		rd(`OFF_WB3_ADDR, 32'h0000_3004);
		ret(1'b0, 16'h7a30, 32'h0000_3000);
		cap(13'h0020, `SIZE_LONG, 2'h0, 3'h0);
		rd(`OFF_STATUS_WORD, 32'h0);
		rd(`OFF_ERR_LOC, 32'h8000_0040);
		rd(`OFF_WB1_ADDR, 32'h8000_0040);
		rd(`OFF_WB_STATUS, 32'h00a9_c200);
		for (int i = 0; i < 4; i++)
			rd(`OFF_LINE0 + 8'(4 * i), line_image_in[i * 32 +: 32]);
		ret(1'b0, 16'h7a40, 32'h0);
		$display("test multi move and push done");
		for (int i = 0; i < 2; i++) begin
			cap(i ? 13'h1c40 : 13'h1240, `SIZE_LONG, 2'h2, 3'h7);
			rd(`OFF_STATUS_WORD, i ? 32'h0516 : 32'h0512);
			rd(`OFF_WB_STATUS, 32'h0);
			rd(`OFF_ERR_LOC, 32'h0001_0003);
		end
		cap(13'h0110, `SIZE_BYTE, 2'h1, 3'h1);
		rd(`OFF_STATUS_WORD, 32'h0000_0029);
		rd(`OFF_WB_STATUS, 32'h00a9_c200);
		for (int i = 0; i < 3; i++) begin
			cap(13'h0004 >> i, `SIZE_LONG, 2'h0, 3'h1);
			rd(`OFF_STATUS_WORD, (32'h2000 << i) | 32'h1);
			ret(1'b0, 16'h7a00 | (16'h0002 << i) | 16'(i == 0),
				32'h0000_3000);
		end
		$display("test status and pending done");
		for (int s = 0; s < 3; s++)
			for (int a = 0; a < 4; a++) begin
				sz = s == 0 ? `SIZE_BYTE : s == 1 ? `SIZE_WORD : `SIZE_LONG;
				{hold1_status, hold2_status, hold3_status} <= {3{1'b1, sz, 5'h01}};
				hold1_addr <= {30'h0000_0400, 2'(a)};
				cap(13'h0, sz, 2'h0, 3'h1);
				lj = s == 0 ? 32'hd400_0000 : s == 1 ? 32'hc3d4_0000 : 32'ha1b2_c3d4;
				mk = s == 0 ? 32'hff : s == 1 ? 32'hffff : 32'hffff_ffff;
				rd(`OFF_WB2_DATA, 32'ha1b2_c3d4 & mk);
				rd(`OFF_WB3_DATA, 32'ha1b2_c3d4 & mk);
				rd(`OFF_WB1_DATA, (lj >> (8 * a)) | (lj << (32 - 8 * a)));
			end
		$display("test alignment done");
		wr(`OFF_FORMAT, 32'h3);
		ret(1'b0, 16'h0100, 32'h0);
		rd(`OFF_FORMAT, 32'h3);
		wr(`OFF_FORMAT, 32'h7);
		ret(1'b1, 16'h0080, 32'h0);
		rd(`OFF_STATUS_WORD, 32'h1);
		addr_err_pc <= 32'h0000_4000;
		addr_err_addr <= 32'h0000_5555;
		addr_err_valid <= 1'b1;
		@(posedge pclk);
		addr_err_valid <= 1'b0;
		@(negedge pclk);
		chk({27'h0, short_frame_valid, short_frame_format}, 32'h12);
		chk(short_frame_addr, 32'h0000_5554);
		chk(short_frame_pc, 32'h0000_4000);
		@(posedge pclk);
		$display("test return and address error done");
		acc_valid <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			{acc_read, acc_rmw, acc_pages_write_ok} <= 3'(i);
			@(posedge pclk);
			@(negedge pclk);
			chk({30'h0, acc_write_check, acc_allowed},
				{30'h0, ~i[2] | i[1], (i[2] & ~i[1]) | i[0]});
			@(posedge pclk);
		end
		$display("test access check done");
		conclude();
	end

	// About fifty times the expected run length.
	initial begin
		#500000;
		fail_count++;
		$display("BAD t=%0t watchdog expired", $time);
		conclude();
	end
endmodule
